// file: pkg/t2rc_defines.vh
/*
  Constants for the timer 2 reload/capture block: reset values,
  wrap value, prescaler ratios and prescaler counter widths.
  Assumes it is included by bare name from hdl/ files.
*/
`ifndef T2RC_DEFINES_VH
`define T2RC_DEFINES_VH

// reset value of every count and reload byte
`define T2RC_BYTE_RST     8'h00
// wrap point of one 8-bit half
`define T2RC_BYTE_MAX     8'hFF
// system clock prescaler ratio
`define T2RC_SYS_DIV      12
// external oscillator prescaler ratio
`define T2RC_EXT_DIV      8
// prescaler counter widths
`define T2RC_SYS_DIV_W    4
`define T2RC_EXT_DIV_W    3

`endif

// file: hdl/t2rc_byte_counter.v
/*
  One 8-bit half of timer 2: software write, reload and increment.
  Assumes all controls are synchronous to clk; inc_en may stay high for many cycles.
*/
`include "t2rc_defines.vh"

module t2rc_byte_counter (
  clk,
  rst_n,
  wr_en,
  wr_data,
  load_en,
  load_val,
  inc_en,
  count_q,
  wrap
);
  input  wire       clk;
  input  wire       rst_n;
  input  wire       wr_en;
  input  wire [7:0] wr_data;
  input  wire       load_en;
  input  wire [7:0] load_val;
  input  wire       inc_en;
  output reg  [7:0] count_q;
  output wire       wrap;

  reg [7:0] count_d;

  // wraps in the cycle it steps from the top value
  assign wrap = inc_en & (count_q == `T2RC_BYTE_MAX);

  // software write wins, then reload, then increment
  always @* begin
    count_d = count_q;
    if (wr_en) begin
      count_d = wr_data;
    end else if (load_en) begin
      count_d = load_val;
    end else if (inc_en) begin
      count_d = count_q + 8'h01;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= `T2RC_BYTE_RST;
    end else begin
      count_q <= count_d;
    end
  end
endmodule // t2rc_byte_counter

// file: hdl/t2rc_timer.v
/*
  Timer 2: 16-bit auto-reload, dual 8-bit auto-reload and comparator
  capture modes, with sysclk, sysclk/12 and external/8 count sources.
  Assumes control ports and the comparator input are synchronous to
  mclk; ext_osc_clk is asynchronous and much slower than mclk.
*/
`include "t2rc_defines.vh"

// Functional notes
// R1 - low and high bytes form one 16-bit auto-reload counter when not split
// R2 - count source is sysclk, sysclk divided by 12, or external/8
// R3 - external divided-by-8 source is synchronised to mclk first
// R4 - 16-bit overflow reloads from reload bytes and sets high flag
// R5 - 16-bit overflow requests interrupt when timer 2 interrupts enabled
// R6 - low byte wrap also requests interrupt when low irq enable set
// R7 - split mode: two 8-bit counters, each reloading from its own byte
// R8 - split mode: run bit gates only the high half; low always runs
// R9 - each half picks sysclk, or sysclk/12 versus external/8 by select
// R10 - split mode: each half wrap sets its own overflow flag
// R11 - split interrupts: high wraps always, low wraps with low irq enable
// R12 - flags are cleared only by software, never by hardware
// R13 - handler reads both flags to find the interrupting half
// R14 - capture mode when capture enabled and not split; sysclk or /12
// R15 - comparator rising edge copies count to reload, sets high flag
// R16 - timer clock should be much faster than the captured signal
// R17 - unsplit modes count only while run bit is set
// R18 - comparator edge detected in mclk domain, one capture per edge
module t2rc_timer #(
  parameter SYS_DIV = `T2RC_SYS_DIV,
  parameter EXT_DIV = `T2RC_EXT_DIV
) (
  mclk,
  rst_n,
  split_mode_select,
  run_control,
  capture_enable,
  external_clock_select,
  high_half_clock_select,
  low_half_clock_select,
  low_overflow_irq_enable,
  timer2_irq_enable,
  ext_osc_clk,
  cmp0_out,
  wr_data,
  count_low_wr,
  count_high_wr,
  reload_low_wr,
  reload_high_wr,
  high_flag_clr,
  low_flag_clr,
  count_low_byte,
  count_high_byte,
  reload_low_byte,
  reload_high_byte,
  high_overflow_flag,
  low_overflow_flag,
  timer2_irq
);
  input  wire       mclk;
  input  wire       rst_n;
  input  wire       split_mode_select;
  input  wire       run_control;
  input  wire       capture_enable;
  input  wire       external_clock_select;
  input  wire       high_half_clock_select;
  input  wire       low_half_clock_select;
  input  wire       low_overflow_irq_enable;
  input  wire       timer2_irq_enable;
  input  wire       ext_osc_clk;
  input  wire       cmp0_out;
  input  wire [7:0] wr_data;
  input  wire       count_low_wr;
  input  wire       count_high_wr;
  input  wire       reload_low_wr;
  input  wire       reload_high_wr;
  input  wire       high_flag_clr;
  input  wire       low_flag_clr;
  output wire [7:0] count_low_byte;
  output wire [7:0] count_high_byte;
  output reg  [7:0] reload_low_byte;
  output reg  [7:0] reload_high_byte;
  output reg        high_overflow_flag;
  output reg        low_overflow_flag;
  output reg        timer2_irq;

  // prescaler end counts, cut to the counter widths on purpose
  localparam integer SYS_LAST_I = SYS_DIV - 1;
  localparam integer EXT_LAST_I = EXT_DIV - 1;
  localparam [`T2RC_SYS_DIV_W-1:0] SYS_LAST = SYS_LAST_I[`T2RC_SYS_DIV_W-1:0];
  localparam [`T2RC_EXT_DIV_W-1:0] EXT_LAST = EXT_LAST_I[`T2RC_EXT_DIV_W-1:0];

  // prescaler and synchroniser state
  reg [`T2RC_SYS_DIV_W-1:0] sys_div_q;
  reg [`T2RC_SYS_DIV_W-1:0] sys_div_d;
  reg [`T2RC_EXT_DIV_W-1:0] ext_div_q;
  reg [`T2RC_EXT_DIV_W-1:0] ext_div_d;
  reg                       ext_meta_q;
  reg                       ext_sync_q;
  reg                       ext_prev_q;
  reg                       cmp_prev_q;

  // next values of software visible state
  reg [7:0] reload_low_d;
  reg [7:0] reload_high_d;
  reg       high_flag_d;
  reg       low_flag_d;
  reg       irq_d;

  // count enables and events
  wire sys_tick;
  wire ext_edge;
  wire ext_tick;
  wire slow_tick;
  wire tick_lo;
  wire tick_hi;
  wire tick_cap;
  wire capture_mode;
  wire inc_lo;
  wire inc_hi;
  wire wrap_lo;
  wire wrap_hi;
  wire load_lo;
  wire load_hi;
  wire cmp_rise;
  wire capture_evt;
  wire set_high;
  wire set_low;

  // R2 sysclk/12 prescaler
  assign sys_tick = (sys_div_q == SYS_LAST);

  always @* begin
    sys_div_d = sys_div_q + 1'b1;
    if (sys_tick) begin
      sys_div_d = {`T2RC_SYS_DIV_W{1'b0}};
    end
  end

  // R3 external clock synchronised then divided
  // rising edges only; a tick trails the pin by one or two clocks
  assign ext_edge = ext_sync_q & ~ext_prev_q;
  assign ext_tick = ext_edge & (ext_div_q == EXT_LAST);

  always @* begin
    ext_div_d = ext_div_q;
    if (ext_edge) begin
      ext_div_d = ext_tick ? {`T2RC_EXT_DIV_W{1'b0}} : ext_div_q + 1'b1;
    end
  end

  // R2 free-running prescalers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sys_div_q <= {`T2RC_SYS_DIV_W{1'b0}};
      ext_div_q <= {`T2RC_EXT_DIV_W{1'b0}};
    end else begin
      sys_div_q <= sys_div_d;
      ext_div_q <= ext_div_d;
    end
  end

  // R3 two-flop synchroniser; third flop only feeds the edge detect
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_osc_clk;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  // R18 comparator history; resets to the idle low level
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_prev_q <= 1'b0;
    end else begin
      cmp_prev_q <= cmp0_out;
    end
  end

  // R9 per-half clock selection
  assign slow_tick = external_clock_select ? ext_tick : sys_tick;
  assign tick_lo   = low_half_clock_select | slow_tick;
  assign tick_hi   = high_half_clock_select | slow_tick;

  // R14 capture mode decode, no external source
  assign capture_mode = capture_enable & ~split_mode_select;
  // capture counts mclk or mclk/12 only; external select ignored
  assign tick_cap     = low_half_clock_select | sys_tick;

  // R8 low half free-runs when split
  // R17 unsplit modes gated by run bit
  assign inc_lo = split_mode_select ? tick_lo :
                  (run_control & (capture_mode ? tick_cap : tick_lo));
  // R1 high byte carries from low byte when not split
  // high steps on the low carry, so one run gate serves both bytes
  assign inc_hi = split_mode_select ? (run_control & tick_hi) : wrap_lo;

  // R4 16-bit reload, R7 split per-half reload
  // capture mode free-runs through the top value without reload
  assign load_lo = split_mode_select ? wrap_lo : (~capture_mode & wrap_hi);
  assign load_hi = wrap_hi & ~capture_mode;

  t2rc_byte_counter u_low (
    .clk      (mclk),
    .rst_n    (rst_n),
    .wr_en    (count_low_wr),
    .wr_data  (wr_data),
    .load_en  (load_lo),
    .load_val (reload_low_byte),
    .inc_en   (inc_lo),
    .count_q  (count_low_byte),
    .wrap     (wrap_lo)
  );

  t2rc_byte_counter u_high (
    .clk      (mclk),
    .rst_n    (rst_n),
    .wr_en    (count_high_wr),
    .wr_data  (wr_data),
    .load_en  (load_hi),
    .load_val (reload_high_byte),
    .inc_en   (inc_hi),
    .count_q  (count_high_byte),
    .wrap     (wrap_hi)
  );

  // R18 one capture per synchronous rising edge
  // a comparator held high gives no further capture
  assign cmp_rise    = cmp0_out & ~cmp_prev_q;
  assign capture_evt = capture_mode & cmp_rise;

  // R10 flag sources per mode, R15 capture sets high flag
  assign set_high = capture_mode ? capture_evt : wrap_hi;
  // low flag marks every low wrap, in every mode
  assign set_low  = wrap_lo;

  // R15 capture copies count; capture beats a software write
  always @* begin
    reload_low_d  = reload_low_byte;
    reload_high_d = reload_high_byte;
    if (capture_evt) begin
      reload_low_d  = count_low_byte;
      reload_high_d = count_high_byte;
    end else begin
      if (reload_low_wr) begin
        reload_low_d = wr_data;
      end
      if (reload_high_wr) begin
        reload_high_d = wr_data;
      end
    end
  end

  // R12 only software clears; a set wins over a clear
  always @* begin
    high_flag_d = high_overflow_flag;
    low_flag_d  = low_overflow_flag;
    if (high_flag_clr) begin
      high_flag_d = 1'b0;
    end
    if (low_flag_clr) begin
      low_flag_d = 1'b0;
    end
    if (set_high) begin
      high_flag_d = 1'b1;
    end
    if (set_low) begin
      low_flag_d = 1'b1;
    end
  end

  // R5 R6 R11 interrupt request from pending flags
  // level request, held until software clears the flag
  always @* begin
    irq_d = timer2_irq_enable &
            (high_flag_d | (low_overflow_irq_enable & low_flag_d));
  end

  // R15 reload bytes double as capture registers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reload_low_byte  <= `T2RC_BYTE_RST;
      reload_high_byte <= `T2RC_BYTE_RST;
    end else begin
      reload_low_byte  <= reload_low_d;
      reload_high_byte <= reload_high_d;
    end
  end

  // R12 sticky flags and the interrupt level
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      high_overflow_flag <= 1'b0;
      low_overflow_flag  <= 1'b0;
      timer2_irq         <= 1'b0;
    end else begin
      high_overflow_flag <= high_flag_d;
      low_overflow_flag  <= low_flag_d;
      timer2_irq         <= irq_d;
    end
  end
endmodule // t2rc_timer

// file: verif/t2rc_chk_asserts.sv
/* Checker: timer 2 port relations over time.
   Assumes binding onto t2rc_timer; sees its ports only. */
module t2rc_chk (
  input logic       mclk,
  input logic       rst_n,
  input logic       split_mode_select,
  input logic       run_control,
  input logic       capture_enable,
  input logic       low_half_clock_select,
  input logic       low_overflow_irq_enable,
  input logic       timer2_irq_enable,
  input logic       cmp0_out,
  input logic       count_low_wr,
  input logic       count_high_wr,
  input logic       high_flag_clr,
  input logic       low_flag_clr,
  input logic [7:0] count_low_byte,
  input logic [7:0] count_high_byte,
  input logic [7:0] reload_low_byte,
  input logic [7:0] reload_high_byte,
  input logic       high_overflow_flag,
  input logic       low_overflow_flag,
  input logic       timer2_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [15:0] cnt = {count_high_byte, count_low_byte};
  wire [15:0] rld = {reload_high_byte, reload_low_byte};
  wire        nw  = !count_low_wr && !count_high_wr;
  wire        s16 = !split_mode_select && !capture_enable;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_hf;
    high_overflow_flag && !high_flag_clr |=> high_overflow_flag;
  endproperty
  a_hf: assert property (p_hf)
    else $error("high flag dropped");
  property p_lf;
    low_overflow_flag && !low_flag_clr |=> low_overflow_flag;
  endproperty
  a_lf: assert property (p_lf)
    else $error("low flag dropped");
  property p_rel;
    s16 && run_control && low_half_clock_select && nw && cnt == 16'hFFFF
      |=> cnt == $past(rld) && high_overflow_flag;
  endproperty
  a_rel: assert property (p_rel)
    else $error("no reload on overflow");
  property p_hold;
    !split_mode_select && !run_control && nw |=> $stable(cnt);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count moved while stopped");
  property p_low;
    split_mode_select && low_half_clock_select && !count_low_wr &&
      count_low_byte != 8'hFF
      |=> count_low_byte == $past(count_low_byte) + 8'h01;
  endproperty
  a_low: assert property (p_low)
    else $error("low half not running");
  property p_high;
    split_mode_select && !run_control && !count_high_wr
      |=> $stable(count_high_byte);
  endproperty
  a_high: assert property (p_high)
    else $error("high half ran while stopped");
  property p_cap;
    capture_enable && !split_mode_select && $rose(cmp0_out)
      |=> rld == $past(cnt) && high_overflow_flag;
  endproperty
  a_cap: assert property (p_cap)
    else $error("capture value wrong");
  property p_irq;
    $stable(timer2_irq_enable) && $stable(low_overflow_irq_enable)
      |-> timer2_irq == (timer2_irq_enable && (high_overflow_flag ||
          low_overflow_irq_enable && low_overflow_flag));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt level wrong");
endmodule // t2rc_chk
bind t2rc_timer t2rc_chk u_t2rc_chk (.*);

// file: verif/t2rc_cmp_model.sv
/* Comparator output model feeding the capture input.
   Assumes callers step it from the bench sequence. */
module t2rc_cmp_model (
  input  logic mclk,
  output logic cmp0_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cmp0_out = 1'b0;
  task edge_to(input logic v);
    @(posedge mclk);
    cmp0_out <= v;
    repeat (20) @(posedge mclk);
  endtask
endmodule // t2rc_cmp_model

// file: verif/tb_top.sv
/* Testbench for t2rc_timer: 16-bit, split, prescaler, capture runs.
   Assumes the comparator model drives cmp0_out. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk = 0, rst_n = 0, ext_osc_clk = 0, cmp0_out;
  logic       split_mode_select = 0, run_control = 0, capture_enable = 0;
  logic       external_clock_select = 0, high_half_clock_select = 1;
  logic       low_half_clock_select = 1, low_overflow_irq_enable = 0;
  logic       timer2_irq_enable = 1, high_flag_clr = 0, low_flag_clr = 0;
  logic       count_low_wr = 0, count_high_wr = 0;
  logic       reload_low_wr = 0, reload_high_wr = 0;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] count_low_byte, count_high_byte;
  logic [7:0] reload_low_byte, reload_high_byte;
  logic       high_overflow_flag, low_overflow_flag, timer2_irq;
  int         n_fail = 0, checks_done = 0, cyc = 0;
  wire [15:0] cnt = {count_high_byte, count_low_byte};
  wire [15:0] rld = {reload_high_byte, reload_low_byte};
  wire [2:0]  flg = {timer2_irq, high_overflow_flag, low_overflow_flag};
  t2rc_timer u_t2rc_timer (.*);
  t2rc_cmp_model u_t2rc_cmp_model (.mclk(mclk), .cmp0_out(cmp0_out));
  always #2 mclk = ~mclk;
  always #11 ext_osc_clk = ~ext_osc_clk;
  task chk(input logic [15:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // s: {reload_high, reload_low, count_high, count_low}
  task wr(input logic [3:0] s, input logic [7:0] d);
    @(posedge mclk);
    {reload_high_wr, reload_low_wr, count_high_wr, count_low_wr} <= s;
    wr_data <= d;
    @(posedge mclk);
    {reload_high_wr, reload_low_wr, count_high_wr, count_low_wr} <= 4'h0;
  endtask
  task w16(input logic [3:0] s, input logic [15:0] v);
    wr(s, v[7:0]);
    wr(s << 1, v[15:8]);
  endtask
  task clr(input logic [1:0] f);
    @(posedge mclk);
    {high_flag_clr, low_flag_clr} <= f;
    @(posedge mclk);
    {high_flag_clr, low_flag_clr} <= 2'h0;
    #1;
  endtask
  task wflag(input int b);
    for (int i = 0; i < 600; i++) begin
      @(posedge mclk);
      #1;
      if (flg[b] === 1'b1) break;
    end
  endtask
  task rate(input int n, input logic [7:0] e);
    logic [15:0] v;
    #1;
    v = cnt;
    repeat (n) @(posedge mclk);
    #1 chk({8'(count_high_byte - v[15:8]), 8'(count_low_byte - v[7:0])},
           {e, e});
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    #1 chk(cnt, 16'h0000);
    chk(rld, 16'h0000);
    chk(flg, 16'h0000);
    w16(4'h4, 16'h1234);
    w16(4'h1, 16'hFFF0);
    @(posedge mclk) run_control <= 1;
    wflag(1);
    chk(cnt, 16'h1234);
    chk(flg, 16'h0007);
    @(posedge mclk) run_control <= 0;
    w16(4'h1, 16'hABCD);
    repeat (8) @(posedge mclk);
    #1 chk(cnt, 16'hABCD);
    clr(2'h2);
    chk(flg, 16'h0001);
    @(posedge mclk) low_overflow_irq_enable <= 1;
    @(posedge mclk);
    #1 chk(flg, 16'h0005);
    clr(2'h1);
    chk(flg, 16'h0000);
    @(posedge mclk) begin
      split_mode_select <= 1;
      low_overflow_irq_enable <= 0;
    end
    wr(4'h4, 8'hF0);
    wr(4'h2, 8'h55);
    wr(4'h8, 8'h80);
    wr(4'h1, 8'hF8);
    wflag(0);
    chk(count_low_byte, 8'hF0);
    chk(flg, 16'h0001);
    chk(count_high_byte, 8'h55);
    @(posedge mclk) run_control <= 1;
    wflag(1);
    chk(count_high_byte, 8'h80);
    chk(flg[2:1], 16'h0003);
    @(posedge mclk) begin
      high_half_clock_select <= 0;
      low_half_clock_select <= 0;
    end
    wr(4'h4, 8'h00);
    wr(4'h1, 8'h00);
    rate(120, 8'h0A);
    @(posedge mclk) external_clock_select <= 1;
    wr(4'h1, 8'h00);
    rate(440, 8'h0A);
    @(posedge mclk) begin
      split_mode_select <= 0;
      run_control <= 0;
      capture_enable <= 1;
      low_half_clock_select <= 1;
    end
    clr(2'h3);
    w16(4'h1, 16'h4321);
    u_t2rc_cmp_model.edge_to(1);
    #1 chk(rld, 16'h4321);
    chk(flg[2:1], 16'h0003);
    clr(2'h2);
    repeat (8) @(posedge mclk);
    #1 chk(flg[2:1], 16'h0000);
    u_t2rc_cmp_model.edge_to(0);
    w16(4'h1, 16'h1111);
    u_t2rc_cmp_model.edge_to(1);
    #1 chk(rld, 16'h1111);
    finish_test;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      finish_test;
    end
  end
  task finish_test;
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
endmodule // tb_top
